// ==== serial_link_consts.svh ====
// offsets, field positions, reset values and sizes for the serial link control pair
`ifndef SERIAL_LINK_CONSTS_SVH
`define SERIAL_LINK_CONSTS_SVH
`define TS_CTRL_OFS 10'h160
`define LINK_EN_OFS 10'h200
`define MODE_OFS 10'h201
`define KM1_OFS 10'h202
`define TS_EN_BIT 0
`define LINK_EN_BIT 0
`define MODE_MSB 5
`define TS_CTRL_RST 8'h00
`define LINK_EN_RST 8'h01
`define MODE_RST 8'h00
`define KM1_RST 8'h1f
`define TS_CTRL_WMASK 8'h01
`define LINK_EN_WMASK 8'h01
`define MODE_WMASK 8'h3f
`define KM1_WMASK 8'hff
`define MODE_64B_FIRST 6'h20
`define KM1_MIN 8'h03
`define ADC_WIDTH 12
`define FIELD_WIDTH 16
`define FIFO_DEPTH 8
`define CMD_OFS 8'h00
`define STATUS_OFS 8'h04
`define CTRL_OFS 8'h08
`define CMD_WRITE_BIT 31
`define CMD_ADDR_LSB 16
`define ST_BUSY_BIT 0
`define ST_REFUSED_BIT 1
`define ST_LINK_BIT 2
`define ST_RDATA_LSB 8
`define CTRL_CAL_BIT 0
`define CTRL_TSRX_BIT 1
`endif

// ==== serial_link_pkg.sv ====
// types for the two ends of the serial link control pair: link state for the converter end, access state for the controller end
package serial_link_pkg;
	typedef enum logic [1:0] {
		LINK_OFF = 2'b00,
		LINK_START = 2'b01,
		LINK_RUN = 2'b10
	} link_state_t;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_REQ = 2'b01,
		ACC_DONE = 2'b10
	} acc_state_t;
endpackage : serial_link_pkg

// ==== serial_link_if.sv ====
// carrier between the converter end and the receiver/controller end
interface serial_link_if #(
	parameter int N = 16
);
	logic cfg_req;
	logic cfg_write;
	logic [9:0] cfg_addr;
	logic [7:0] cfg_wdata;
	logic [7:0] cfg_rdata;
	logic cfg_ack;
	logic [N-1:0] lane_data;
	logic lane_valid;
	logic lane_ready;
	logic lane_mf_start;
	logic lane_active;
	logic [1:0] ila_cs;
	logic [7:0] ila_km1;
	modport device (
		input cfg_req, cfg_write, cfg_addr, cfg_wdata, lane_ready,
		output cfg_rdata, cfg_ack, lane_data, lane_valid, lane_mf_start, lane_active,
		output ila_cs, ila_km1
	);
	modport host (
		output cfg_req, cfg_write, cfg_addr, cfg_wdata, lane_ready,
		input cfg_rdata, cfg_ack, lane_data, lane_valid, lane_mf_start, lane_active,
		input ila_cs, ila_km1
	);
endinterface : serial_link_if

// ==== serial_link_device.sv ====
// converter end: link control registers, sample fifo, multiframe counter
//
// The cfg_req/cfg_ack register port was decided locally.
`include "serial_link_consts.svh"

// word fifo with registered ready/valid flags and a synchronous flush
module sample_fifo #(
	parameter int WIDTH = `FIELD_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic flush,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic in_ready_reg;
	logic out_valid_reg;
	wire push = in_valid & in_ready_reg;
	wire pop = out_valid_reg & out_ready;

	// refuse sizes the pointers cannot serve
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("sample_fifo: depth below 2 or no width");
	end

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	// occupancy after this edge
	assign count_next = flush ? '0 : count_reg + CW'(push) - CW'(pop);
	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data = mem_reg[rd_ptr_reg];

	// storage, indexed by write pointer
	always_ff @(posedge clk) begin
		if (push) mem_reg[wr_ptr_reg] <= in_data;
	end

	// pointers and honest full/empty flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_reg <= 1'b0;
			out_valid_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= flush ? '0 : (push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg);
			rd_ptr_reg <= flush ? '0 : (pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg);
			count_reg <= count_next;
			in_ready_reg <= ~flush & (count_next != FULL_COUNT);
			out_valid_reg <= ~flush & (count_next != '0);
		end
	end
endmodule : sample_fifo

module serial_link_device
	import serial_link_pkg::*;
#(
	parameter int ADC_W = `ADC_WIDTH,
	parameter int N = `FIELD_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [ADC_W-1:0] SAMPLE_DATA,
	input wire logic SAMPLE_VALID,
	output logic SAMPLE_READY,
	input wire logic TIMESTAMP_IN,
	input wire logic SYSREF_IN,
	output logic SERDES_POWER_ON,
	output logic LINK_CLK_ON,
	output logic LINK_RUNNING,
	serial_link_if.device LINK
);
	logic [7:0] ts_ctrl_reg;
	logic [7:0] link_enable_reg;
	logic [7:0] link_output_mode_reg;
	logic [7:0] frames_per_multiframe_reg;
	logic [7:0] rdata_reg;
	logic ack_reg;
	logic serdes_on_reg;
	logic clk_on_reg;
	link_state_t state_reg;
	link_state_t state_next;
	logic running_reg;
	logic [7:0] act_km1_reg;
	logic [7:0] mf_count_reg;
	logic [N-1:0] field;
	logic [N-1:0] lane_field;
	logic fifo_out_valid;

	// refuse a field that cannot hold the sample
	if (N < ADC_W || ADC_W < 1) begin : g_bad_width
		$error("serial_link_device: field narrower than sample");
	end

	// sample placed at the field top; timestamp takes the field LSB
	function automatic logic [N-1:0] format_field(input logic [ADC_W-1:0] adc,
		input logic ts, input logic ts_en);
		logic [N-1:0] f;
		f = N'(adc) << (N - ADC_W);
		if (ts_en) f[0] = ts;
		format_field = f;
	endfunction : format_field

	// frames per multiframe minus one, 64B/66B taking it from the mode
	function automatic logic [7:0] eff_km1(input logic [`MODE_MSB:0] mode,
		input logic [7:0] km1);
		logic [8:0] k;
		k = 9'h100 >> mode[1:0];
		eff_km1 = (mode >= `MODE_64B_FIRST) ? 8'(k - 9'h001) : km1;
	endfunction : eff_km1

	// register port decode
	wire cfg_wr = LINK.cfg_req & LINK.cfg_write & ~ack_reg;
	wire wr_ts = cfg_wr & (LINK.cfg_addr == `TS_CTRL_OFS);
	wire wr_en = cfg_wr & (LINK.cfg_addr == `LINK_EN_OFS);
	wire wr_mode = cfg_wr & (LINK.cfg_addr == `MODE_OFS);
	wire wr_km1 = cfg_wr & (LINK.cfg_addr == `KM1_OFS);
	wire link_en = link_enable_reg[`LINK_EN_BIT];
	wire ts_en = ts_ctrl_reg[`TS_EN_BIT];
	wire link_run = (state_reg == LINK_RUN);
	wire flush = ~link_run;
	wire frame_take = fifo_out_valid & LINK.lane_ready;
	wire [7:0] rd_mux = (LINK.cfg_addr == `TS_CTRL_OFS) ? ts_ctrl_reg :
		(LINK.cfg_addr == `LINK_EN_OFS) ? link_enable_reg :
		(LINK.cfg_addr == `MODE_OFS) ? link_output_mode_reg :
		(LINK.cfg_addr == `KM1_OFS) ? frames_per_multiframe_reg : 8'h00;

	// register storage; reserved bits stored as written
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ts_ctrl_reg <= `TS_CTRL_RST;
			link_enable_reg <= `LINK_EN_RST;
			link_output_mode_reg <= `MODE_RST;
			frames_per_multiframe_reg <= `KM1_RST;
		end else begin
			if (wr_ts) ts_ctrl_reg <= LINK.cfg_wdata;
			if (wr_en) link_enable_reg <= LINK.cfg_wdata;
			if (wr_mode) link_output_mode_reg <= LINK.cfg_wdata;
			if (wr_km1) frames_per_multiframe_reg <= LINK.cfg_wdata;
		end
	end

	// one-cycle acknowledge per request, read data with it
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			ack_reg <= LINK.cfg_req & ~ack_reg;
			rdata_reg <= (LINK.cfg_req & ~ack_reg) ? rd_mux : rdata_reg;
		end
	end

	// link state: off while disabled, one start cycle, then running
	always_comb begin
		case (state_reg)
			LINK_OFF: state_next = link_en ? LINK_START : LINK_OFF;
			LINK_START: state_next = link_en ? LINK_RUN : LINK_OFF;
			LINK_RUN: state_next = link_en ? LINK_RUN : LINK_OFF;
			default: state_next = LINK_OFF;
		endcase
	end

	// state, power and clock gates follow the enable bit
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= LINK_OFF;
			running_reg <= 1'b0;
			serdes_on_reg <= 1'b0;
			clk_on_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			running_reg <= (state_next == LINK_RUN);
			serdes_on_reg <= link_en;
			clk_on_reg <= link_en;
		end
	end

	// mode and K are only picked up on the start cycle
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			act_km1_reg <= `KM1_RST;
		end else if (state_reg == LINK_START) begin
			act_km1_reg <= eff_km1(link_output_mode_reg[`MODE_MSB:0],
				frames_per_multiframe_reg);
		end
	end

	// multiframe counter: reset while off, SYSREF aligns only when running
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mf_count_reg <= 8'h00;
		end else if (flush) begin
			mf_count_reg <= 8'h00;
		end else if (SYSREF_IN) begin
			mf_count_reg <= 8'h00;
		end else if (frame_take) begin
			mf_count_reg <= (mf_count_reg == act_km1_reg) ? 8'h00 : mf_count_reg + 8'h01;
		end
	end

	// timestamp formatted on entry so it rides the fifo with its sample
	assign field = format_field(SAMPLE_DATA, TIMESTAMP_IN, ts_en);

	sample_fifo #(
		.WIDTH(N),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.flush(flush),
		.in_data(field),
		.in_valid(SAMPLE_VALID),
		.in_ready(SAMPLE_READY),
		.out_data(lane_field),
		.out_valid(fifo_out_valid),
		.out_ready(LINK.lane_ready)
	);

	// link side outputs
	assign LINK.lane_data = lane_field;
	assign LINK.lane_valid = fifo_out_valid;
	assign LINK.lane_mf_start = fifo_out_valid & link_run & (mf_count_reg == 8'h00);
	assign LINK.lane_active = link_run;
	assign LINK.ila_cs = 2'b00;
	assign LINK.ila_km1 = act_km1_reg;
	assign LINK.cfg_ack = ack_reg;
	assign LINK.cfg_rdata = rdata_reg;
	assign SERDES_POWER_ON = serdes_on_reg;
	assign LINK_CLK_ON = clk_on_reg;
	assign LINK_RUNNING = running_reg;
endmodule : serial_link_device

// ==== serial_link_host.sv ====
// receiver/controller end: AHB-Lite command registers, checked config access, lane sink
`include "serial_link_consts.svh"

module serial_link_host
	import serial_link_pkg::*;
#(
	parameter int N = `FIELD_WIDTH
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic CAL_ENABLE,
	output logic TIMESTAMP_RECV_ENABLE,
	output logic [N-1:0] RX_DATA,
	output logic RX_TIMESTAMP,
	output logic RX_VALID,
	output logic RX_MF_START,
	input wire logic RX_READY,
	serial_link_if.host LINK
);
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic dph_wr_reg;
	logic [7:0] dph_addr_reg;
	logic cal_reg;
	logic tsrx_reg;
	logic link_shadow_reg;
	logic refused_reg;
	logic [7:0] last_rdata_reg;
	acc_state_t acc_reg;
	logic req_wr_reg;
	logic [9:0] req_addr_reg;
	logic [7:0] req_wdata_reg;
	logic [N-1:0] rx_data_reg;
	logic rx_ts_reg;
	logic rx_valid_reg;
	logic rx_mf_reg;
	localparam logic [7:0] LINK_EN_RESET = `LINK_EN_RST;

	// refuse a lane field with no bits
	if (N < 1) begin : g_bad_width
		$error("serial_link_host: lane field has no bits");
	end

	// writable bits of each device register; reserved bits forced to zero
	function automatic logic [7:0] wmask(input logic [9:0] a);
		case (a)
			`TS_CTRL_OFS: wmask = `TS_CTRL_WMASK;
			`LINK_EN_OFS: wmask = `LINK_EN_WMASK;
			`MODE_OFS: wmask = `MODE_WMASK;
			`KM1_OFS: wmask = `KM1_WMASK;
			default: wmask = 8'h00;
		endcase
	endfunction : wmask

	// bus decode
	wire take = HSEL & HTRANS[1] & HREADY;
	wire busy = (acc_reg != ACC_IDLE);
	wire cmd_wr = dph_wr_reg & (dph_addr_reg == `CMD_OFS);
	wire ctrl_wr = dph_wr_reg & (dph_addr_reg == `CTRL_OFS);
	wire c_write = HWDATA[`CMD_WRITE_BIT];
	wire [9:0] c_addr = HWDATA[`CMD_ADDR_LSB +: 10];
	wire [7:0] c_data = HWDATA[7:0] & wmask(c_addr);
	wire bad_en = c_addr == `LINK_EN_OFS && c_data[`LINK_EN_BIT] && !cal_reg;
	wire bad_cfg = (c_addr == `MODE_OFS || c_addr == `KM1_OFS
		|| c_addr == `TS_CTRL_OFS) && link_shadow_reg;
	wire bad_mode = c_addr == `MODE_OFS && cal_reg;
	wire bad_km1 = c_addr == `KM1_OFS && c_data < `KM1_MIN;
	wire cmd_bad = busy | (c_write & (bad_en | bad_cfg | bad_mode | bad_km1));
	wire cal_bad = ~HWDATA[`CTRL_CAL_BIT] & cal_reg & link_shadow_reg;
	wire ts_on_wr = c_write & (c_addr == `TS_CTRL_OFS) & c_data[`TS_EN_BIT];
	wire [31:0] status_word = {16'h0000, last_rdata_reg, 5'b00000, link_shadow_reg,
		refused_reg, busy};
	wire [31:0] rd_mux = (HADDR[7:0] == `STATUS_OFS) ? status_word :
		(HADDR[7:0] == `CTRL_OFS) ? {30'h0, tsrx_reg, cal_reg} : 32'h0;
	wire lane_take = LINK.lane_valid & LINK.lane_ready;

	// address phase capture and zero-wait read data
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dph_wr_reg <= 1'b0;
			dph_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0;
			hreadyout_reg <= 1'b1;
		end else begin
			dph_wr_reg <= take & HWRITE;
			dph_addr_reg <= take ? HADDR[7:0] : dph_addr_reg;
			hrdata_reg <= (take & ~HWRITE) ? rd_mux : 32'h0;
			hreadyout_reg <= 1'b1;
		end
	end

	// control bits and the sticky refusal flag, set winning over clear
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cal_reg <= 1'b0;
			tsrx_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			if (ctrl_wr) cal_reg <= cal_bad ? cal_reg : HWDATA[`CTRL_CAL_BIT];
			if (ctrl_wr) tsrx_reg <= HWDATA[`CTRL_TSRX_BIT];
			else if (cmd_wr & ~cmd_bad & ts_on_wr) tsrx_reg <= 1'b1;
			if ((cmd_wr & cmd_bad) | (ctrl_wr & cal_bad)) refused_reg <= 1'b1;
			else if (cmd_wr) refused_reg <= 1'b0;
		end
	end

	// device register access: request held until the one-cycle ack
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			acc_reg <= ACC_IDLE;
			req_wr_reg <= 1'b0;
			req_addr_reg <= 10'h000;
			req_wdata_reg <= 8'h00;
			last_rdata_reg <= 8'h00;
			link_shadow_reg <= LINK_EN_RESET[`LINK_EN_BIT];
		end else begin
			case (acc_reg)
				ACC_IDLE: begin
					if (cmd_wr & ~cmd_bad) begin
						acc_reg <= ACC_REQ;
						req_wr_reg <= c_write;
						req_addr_reg <= c_addr;
						req_wdata_reg <= c_data;
					end
				end
				ACC_REQ: begin
					if (LINK.cfg_ack) begin
						acc_reg <= ACC_DONE;
						last_rdata_reg <= req_wr_reg ? last_rdata_reg : LINK.cfg_rdata;
						if (req_wr_reg && req_addr_reg == `LINK_EN_OFS)
							link_shadow_reg <= req_wdata_reg[`LINK_EN_BIT];
					end
				end
				ACC_DONE: acc_reg <= ACC_IDLE;
				default: acc_reg <= ACC_IDLE;
			endcase
		end
	end

	// lane sink with one output stage; back-pressure reaches the device fifo
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_data_reg <= '0;
			rx_ts_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_mf_reg <= 1'b0;
		end else if (~rx_valid_reg | RX_READY) begin
			rx_valid_reg <= lane_take;
			rx_data_reg <= lane_take ? LINK.lane_data : rx_data_reg;
			rx_ts_reg <= lane_take & tsrx_reg & LINK.lane_data[0];
			rx_mf_reg <= lane_take & LINK.lane_mf_start;
		end
	end

	assign LINK.cfg_req = (acc_reg == ACC_REQ);
	assign LINK.cfg_write = req_wr_reg;
	assign LINK.cfg_addr = req_addr_reg;
	assign LINK.cfg_wdata = req_wdata_reg;
	assign LINK.lane_ready = ~rx_valid_reg | RX_READY;
	assign HRDATA = hrdata_reg;
	assign HREADYOUT = hreadyout_reg;
	assign HRESP = 1'b0;
	assign CAL_ENABLE = cal_reg;
	assign TIMESTAMP_RECV_ENABLE = tsrx_reg;
	assign RX_DATA = rx_data_reg;
	assign RX_TIMESTAMP = rx_ts_reg;
	assign RX_VALID = rx_valid_reg;
	assign RX_MF_START = rx_mf_reg;
endmodule : serial_link_host

// ==== serial_link_props.sv ====
// concurrent checks on the carrier between the converter end and the controller end
`include "serial_link_consts.svh"

module serial_link_props (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [9:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic lane_valid,
	input wire logic lane_mf_start,
	input wire logic lane_active,
	input wire logic [1:0] ila_cs,
	input wire logic [7:0] ila_km1
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!ARST_N);
	// steps of one config access
	sequence req_start;
		$rose(cfg_req);
	endsequence
	sequence ack_pulse;
		cfg_ack ##1 !cfg_ack;
	endsequence
	// decoded config traffic
	logic en_wr;
	logic cfg_wr;
	logic quiet_ofs;
	assign en_wr = cfg_ack && cfg_write && cfg_addr == `LINK_EN_OFS;
	assign cfg_wr = cfg_req && cfg_write;
	assign quiet_ofs = cfg_addr == `MODE_OFS || cfg_addr == `KM1_OFS || cfg_addr == `TS_CTRL_OFS;
	a_ila_no_cs: assert property (ila_cs == 2'b00)
		else $error("lane alignment reports control bits");
	a_mf_quiet_off: assert property (!lane_active |-> !lane_mf_start)
		else $error("multiframe start while link off");
	a_lane_flushed: assert property (!lane_active ##1 !lane_active |-> !lane_valid)
		else $error("lane data while link off");
	a_km1_held_run: assert property (lane_active ##1 lane_active |-> $stable(ila_km1))
		else $error("active K changed while running");
	a_link_stops: assert property (en_wr && !cfg_wdata[0] |-> ##[1:3] !lane_active)
		else $error("link still running after disable");
	a_link_starts: assert property (en_wr && cfg_wdata[0] |-> ##[1:6] lane_active)
		else $error("link not running after enable");
	a_quiet_cfg: assert property (cfg_wr && quiet_ofs |-> !lane_active)
		else $error("config change while link running");
	a_mode_reserved: assert property (cfg_wr && cfg_addr == `MODE_OFS |-> cfg_wdata[7:6] == 2'b00)
		else $error("reserved mode bits written nonzero");
	a_ack_one_pulse: assert property (req_start |=> ack_pulse)
		else $error("config ack not a single pulse after request");
	a_km1_floor: assert property (lane_active |-> ila_km1 >= `KM1_MIN)
		else $error("active K below minimum");
endmodule : serial_link_props

// ==== tb_top.sv ====
// self-checking bench for the converter end and controller end joined by their carrier
`include "serial_link_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 0;
	logic ARST_N = 0;
	logic HSEL = 0;
	logic [31:0] HADDR = 0;
	logic [1:0] HTRANS = 0;
	logic HWRITE = 0;
	logic [2:0] HSIZE = 0;
	int mf_cnt = 0;
	int k_exp = 32;
	logic [31:0] HWDATA = 0;
	logic [31:0] HRDATA;
	logic HREADYOUT, HRESP, CAL_ENABLE, TIMESTAMP_RECV_ENABLE;
	logic [15:0] RX_DATA;
	logic RX_TIMESTAMP, RX_VALID, RX_MF_START, SAMPLE_READY;
	logic RX_READY = 1;
	logic [11:0] SAMPLE_DATA = 12'h0a5;
	logic SAMPLE_VALID = 0;
	logic TIMESTAMP_IN = 0;
	logic SYSREF_IN = 0;
	logic SERDES_POWER_ON, LINK_CLK_ON, LINK_RUNNING;
	logic ts_on = 0;
	logic [15:0] exp;
	logic [15:0] exp_q[$];
	int mismatches = 0;
	int tests_run = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	serial_link_if #(.N(16)) u_serial_link_if ();
	serial_link_device u_serial_link_device (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
		.SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
		.TIMESTAMP_IN(TIMESTAMP_IN), .SYSREF_IN(SYSREF_IN), .SERDES_POWER_ON(SERDES_POWER_ON),
		.LINK_CLK_ON(LINK_CLK_ON), .LINK_RUNNING(LINK_RUNNING), .LINK(u_serial_link_if));
	serial_link_host u_serial_link_host (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.CAL_ENABLE(CAL_ENABLE), .TIMESTAMP_RECV_ENABLE(TIMESTAMP_RECV_ENABLE),
		.RX_DATA(RX_DATA), .RX_TIMESTAMP(RX_TIMESTAMP), .RX_VALID(RX_VALID),
		.RX_MF_START(RX_MF_START), .RX_READY(RX_READY), .LINK(u_serial_link_if));
	serial_link_props u_serial_link_props (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
		.cfg_req(u_serial_link_if.cfg_req), .cfg_write(u_serial_link_if.cfg_write),
		.cfg_addr(u_serial_link_if.cfg_addr), .cfg_wdata(u_serial_link_if.cfg_wdata),
		.cfg_ack(u_serial_link_if.cfg_ack), .lane_valid(u_serial_link_if.lane_valid),
		.lane_mf_start(u_serial_link_if.lane_mf_start), .lane_active(u_serial_link_if.lane_active),
		.ila_cs(u_serial_link_if.ila_cs), .ila_km1(u_serial_link_if.ila_km1));
	task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : check
	task automatic results();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	// one single bus transfer, address phase then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge SYS_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= wr;
		HSIZE <= 3'h2;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask : ahb
	// device access by command word, then poll until idle
	task automatic cfg(input logic wr, input logic [9:0] ofs, input logic [7:0] d, output logic [31:0] st);
		logic [31:0] r;
		ahb(1'b1, `CMD_OFS, {wr, 5'h00, ofs, 8'h00, d}, r);
		st = 32'h1;
		while (st[`ST_BUSY_BIT] !== 1'b0) ahb(1'b0, `STATUS_OFS, 32'h0, st);
	endtask : cfg
	task automatic put(input logic [9:0] ofs, input logic [7:0] d, input logic refused);
		logic [31:0] st;
		cfg(1'b1, ofs, d, st);
		check("refused", {31'h0, refused}, {31'h0, st[`ST_REFUSED_BIT]});
	endtask : put
	task automatic get(input logic [9:0] ofs, input logic [7:0] e);
		logic [31:0] st;
		cfg(1'b0, ofs, 8'h00, st);
		check("cfg_rdata", {24'h0, e}, {24'h0, st[15:8]});
	endtask : get
	task automatic ctrl(input logic [1:0] v);
		logic [31:0] r;
		ahb(1'b1, `CTRL_OFS, {30'h0, v}, r);
		@(posedge SYS_CLK);
	endtask : ctrl
	task automatic wait_run(input logic v);
		int k = 0;
		while (LINK_RUNNING !== v && k < 20) begin
			@(posedge SYS_CLK);
			k++;
		end
		check("link_running", {31'h0, v}, {31'h0, LINK_RUNNING});
	endtask : wait_run
	// sample stream with the far side ready or stalled, then drained
	task automatic stream(input int cyc, input logic rdy);
		int acc = 0;
		RX_READY <= rdy;
		SAMPLE_VALID <= 1'b1;
		for (int k = 0; k < cyc; k++) begin
			@(posedge SYS_CLK);
			if (SAMPLE_READY === 1'b1) begin
				acc++;
				SAMPLE_DATA <= SAMPLE_DATA + 12'h13b;
				TIMESTAMP_IN <= ~TIMESTAMP_IN;
			end
		end
		check("in_ready", {31'h0, rdy}, {31'h0, SAMPLE_READY});
		check("fill", 32'h1, {31'h0, rdy || acc >= `FIFO_DEPTH});
		SAMPLE_VALID <= 1'b0;
		RX_READY <= 1'b1;
		repeat (20) @(posedge SYS_CLK);
		check("drained", 32'h0, exp_q.size());
	endtask : stream
	// expected fields follow every accepted sample
	always @(posedge SYS_CLK) begin
		if (LINK_RUNNING !== 1'b1)
			mf_cnt = 0;
		if (SAMPLE_VALID === 1'b1 && SAMPLE_READY === 1'b1)
			exp_q.push_back({SAMPLE_DATA, 3'b000, TIMESTAMP_IN & ts_on});
		if (RX_VALID === 1'b1 && RX_READY === 1'b1) begin
			exp = exp_q.size() != 0 ? exp_q.pop_front() : 16'hxxxx;
			check("rx_field", {15'h0, exp, exp[0]}, {15'h0, RX_DATA, RX_TIMESTAMP});
			check("rx_mf_start", {31'h0, mf_cnt % k_exp == 0}, {31'h0, RX_MF_START});
			mf_cnt++;
		end
	end
	task automatic t_reset();
		logic [31:0] r;
		wait_run(1'b1);
		check("serdes_on", 32'h1, {31'h0, SERDES_POWER_ON});
		check("link_clk_on", 32'h1, {31'h0, LINK_CLK_ON});
		check("hresp", 32'h0, {31'h0, HRESP});
		get(`TS_CTRL_OFS, `TS_CTRL_RST);
		get(`LINK_EN_OFS, `LINK_EN_RST);
		get(`MODE_OFS, `MODE_RST);
		get(`KM1_OFS, `KM1_RST);
		get(10'h300, 8'h00);
		check("ila_km1", 32'h1f, {24'h0, u_serial_link_if.ila_km1});
		check("ila_cs", 32'h0, {30'h0, u_serial_link_if.ila_cs});
		ahb(1'b0, 8'h10, 32'h0, r);
		check("unmapped", 32'h0, r);
		ahb(1'b0, `STATUS_OFS, 32'h0, r);
		check("shadow", 32'h1, {31'h0, r[`ST_LINK_BIT]});
	endtask : t_reset
	task automatic t_refuse();
		put(`MODE_OFS, 8'h01, 1'b1);
		put(`KM1_OFS, 8'h0f, 1'b1);
		put(`TS_CTRL_OFS, 8'h01, 1'b1);
		get(`MODE_OFS, 8'h00);
		get(`KM1_OFS, 8'h1f);
	endtask : t_refuse
	task automatic t_off();
		put(`LINK_EN_OFS, 8'h00, 1'b0);
		wait_run(1'b0);
		check("serdes", 32'h0, {31'h0, SERDES_POWER_ON});
		check("link_clk", 32'h0, {31'h0, LINK_CLK_ON});
		SYSREF_IN <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		SYSREF_IN <= 1'b0;
		put(`LINK_EN_OFS, 8'h01, 1'b1);
		repeat (6) @(posedge SYS_CLK);
		check("stay_off", 32'h0, {31'h0, LINK_RUNNING});
	endtask : t_off
	task automatic t_modes();
		put(`MODE_OFS, 8'he1, 1'b0);
		get(`MODE_OFS, 8'h21);
		put(`KM1_OFS, 8'h02, 1'b1);
		put(`KM1_OFS, 8'h0f, 1'b0);
		put(`TS_CTRL_OFS, 8'h01, 1'b0);
		check("tsrx_auto", 32'h1, {31'h0, TIMESTAMP_RECV_ENABLE});
		ts_on = 1'b1;
		ctrl(2'b11);
		put(`LINK_EN_OFS, 8'h01, 1'b0);
		wait_run(1'b1);
		check("km1_64b", 32'h7f, {24'h0, u_serial_link_if.ila_km1});
		ctrl(2'b10);
		check("cal_kept", 32'h1, {31'h0, CAL_ENABLE});
		put(`LINK_EN_OFS, 8'h00, 1'b0);
		wait_run(1'b0);
		ctrl(2'b10);
		put(`MODE_OFS, 8'h00, 1'b0);
		ctrl(2'b11);
		put(`LINK_EN_OFS, 8'h01, 1'b0);
		wait_run(1'b1);
		check("km1_8b", 32'h0f, {24'h0, u_serial_link_if.ila_km1});
		k_exp = 16;
	endtask : t_modes
	initial begin
		repeat (2) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		t_reset();
		stream(30, 1'b0);
		stream(12, 1'b1);
		t_refuse();
		t_off();
		t_modes();
		stream(12, 1'b1);
		results();
	end
	// hang guard well beyond the expected run length
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		mismatches++;
		results();
	end
endmodule : tb_top
